// ===== hdl/ecit_capture_slot.v
// one capture register with first-edge hold
module ecit_capture_slot (
  input wire CLK,
  input wire RESET,
  input wire EVENT,
  input wire [7:0] VALUE,
  input wire HOLD,
  input wire READ,
  input wire WRITE,
  input wire [7:0] WDATA,
  output wire [7:0] DATA
);
  reg [7:0] data_r;
  reg full_r;
  always @(posedge CLK) begin
    if (RESET) begin
      data_r <= 8'h00;
      full_r <= 1'b0;
    end else begin
      // an edge beats a read in the same cycle, and beats a write unless hold keeps a full slot that is not being read
      if (EVENT && !(HOLD && full_r && !READ)) begin
        data_r <= VALUE;
      end else if (WRITE) begin
        data_r <= WDATA;
      end
      if (EVENT) begin
        full_r <= 1'b1;
      end else if (READ) begin
        full_r <= 1'b0;
      end
    end
  end
  assign DATA = data_r;
endmodule // ecit_capture_slot

// ===== hdl/ecit_defines.vh
// constants for the edge capture and interval timer block
`ifndef ECIT_DEFINES_VH
`define ECIT_DEFINES_VH
// word index; byte address is index times four
`define ECIT_IDX_FRT_LOW 6'h20
`define ECIT_IDX_FRT_HIGH 6'h21
`define ECIT_IDX_C0_RISE 6'h22
`define ECIT_IDX_C1_RISE 6'h23
`define ECIT_IDX_C0_FALL 6'h24
`define ECIT_IDX_C1_FALL 6'h25
`define ECIT_IDX_INT_LOW 6'h26
`define ECIT_IDX_INT_HIGH 6'h27
`define ECIT_IDX_REL_LOW 6'h28
`define ECIT_IDX_REL_HIGH 6'h29
`define ECIT_IDX_CONFIG 6'h2A
`define ECIT_IDX_CAP_MASK 6'h2B
`define ECIT_IDX_CAP_STAT 6'h2C
`define ECIT_IDX_INT_STAT 6'h2D
`define ECIT_IDX_INT_MASK 6'h2E
// configuration fields
`define ECIT_CFG_HOLD 7
`define ECIT_CFG_SEL_HI 6
`define ECIT_CFG_SEL_LO 4
`define ECIT_CFG_WIDE 3
`define ECIT_CFG_WMASK 8'hF8
`define ECIT_RESET_BYTE 8'h00
`define ECIT_RESP_OKAY 2'h0
`define ECIT_RESP_SLVERR 2'h2
`endif

// ===== hdl/ecit_edge_sync.v
// two-stage synchroniser with rise and fall pulses
module ecit_edge_sync (
  input wire CLK,
  input wire RESET,
  input wire PIN,
  output wire RISE,
  output wire FALL
);
  reg meta_r;
  reg sync_r;
  reg prev_r;
  always @(posedge CLK) begin
    if (RESET) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= PIN;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign RISE = sync_r & ~prev_r;
  assign FALL = ~sync_r & prev_r;
endmodule // ecit_edge_sync

// ===== hdl/ecit_top.v
// edge capture and interval timer with axi4-lite slave
//
// The AXI4-Lite register port is this design's own decision.
`include "ecit_defines.vh"
module ecit_top (
  input wire CLK,
  input wire RESET,
  input wire CAPTURE_INPUT_ZERO,
  input wire CAPTURE_INPUT_ONE,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  output reg IRQ
);
  // ****************************************
  // functions
  // ****************************************
  function mapped;
    input [5:0] idx;
    begin
      mapped = (idx >= `ECIT_IDX_FRT_LOW) && (idx <= `ECIT_IDX_INT_MASK);
    end
  endfunction
  function [7:0] slice;
    input [15:0] t;
    input [2:0] n;
    begin
      slice = t[n +: 8];
    end
  endfunction
  // one address match, gated by the strobe that qualifies it
  function hit;
    input en;
    input [5:0] got;
    input [5:0] want;
    begin
      hit = en && (got == want);
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg [15:0] frt_r;
  reg [7:0] frt_hold_r;
  reg [7:0] frt_wlow_r;
  reg [11:0] icount_r;
  reg [3:0] ihold_r;
  reg [7:0] reload_low_r;
  reg [3:0] reload_high_r;
  reg [11:0] reload_r;
  reg [7:0] config_r;
  reg [3:0] cap_mask_r;
  reg [3:0] cap_stat_r;
  reg int_stat_r;
  reg int_mask_r;
  reg aw_got_r;
  reg w_got_r;
  reg [5:0] aw_idx_r;
  reg [7:0] wbyte_r;
  reg wlane_r;
  wire [3:0] edge_ev;
  wire [3:0] slot_ev;
  wire [31:0] slot_data;
  wire [3:0] slot_rd;
  wire [3:0] slot_wr;
  wire wide = config_r[`ECIT_CFG_WIDE];
  wire [7:0] cap_val = slice(frt_r, config_r[`ECIT_CFG_SEL_HI:`ECIT_CFG_SEL_LO]);

  // ****************************************
  // capture inputs
  // ****************************************
  ecit_edge_sync u_sync0 (
    .CLK(CLK),
    .RESET(RESET),
    .PIN(CAPTURE_INPUT_ZERO),
    .RISE(edge_ev[0]),
    .FALL(edge_ev[1])
  );
  ecit_edge_sync u_sync1 (
    .CLK(CLK),
    .RESET(RESET),
    .PIN(CAPTURE_INPUT_ONE),
    .RISE(edge_ev[2]),
    .FALL(edge_ev[3])
  );
  // slot order: zero-rise, zero-fall, one-rise, one-fall; in wide mode slots 2 and 3 take zero-rise and zero-fall
  assign slot_ev[0] = edge_ev[0];
  assign slot_ev[1] = edge_ev[1];
  assign slot_ev[2] = wide ? edge_ev[0] : edge_ev[2];
  assign slot_ev[3] = wide ? edge_ev[1] : edge_ev[3];

  // ****************************************
  // bus decode
  // ****************************************
  wire wr_fire = aw_got_r && w_got_r && !S_AXI_BVALID;
  wire rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
  wire [5:0] ar_idx = S_AXI_ARADDR[7:2];
  wire wr_ok = wr_fire && mapped(aw_idx_r) && wlane_r;
  wire rd_ok = rd_fire && mapped(ar_idx);

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_slot
      wire [5:0] gidx = (g == 0) ? `ECIT_IDX_C0_RISE : (g == 1) ? `ECIT_IDX_C0_FALL :
        (g == 2) ? `ECIT_IDX_C1_RISE : `ECIT_IDX_C1_FALL;
      wire [7:0] gval = (g >= 2 && wide) ? frt_r[15:8] : (wide ? frt_r[7:0] : cap_val);
      assign slot_rd[g] = hit(rd_ok, ar_idx, gidx);
      assign slot_wr[g] = hit(wr_ok, aw_idx_r, gidx);
      ecit_capture_slot u_slot (
        .CLK(CLK),
        .RESET(RESET),
        .EVENT(slot_ev[g]),
        .VALUE(gval),
        .HOLD(config_r[`ECIT_CFG_HOLD]),
        .READ(slot_rd[g]),
        .WRITE(slot_wr[g]),
        .WDATA(wbyte_r),
        .DATA(slot_data[g*8 +: 8])
      );
    end
  endgenerate

  // ****************************************
  // read mux
  // ****************************************
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    case (ar_idx)
      `ECIT_IDX_FRT_LOW: rd_byte = frt_r[7:0];
      `ECIT_IDX_FRT_HIGH: rd_byte = frt_hold_r;
      `ECIT_IDX_C0_RISE: rd_byte = slot_data[7:0];
      `ECIT_IDX_C0_FALL: rd_byte = slot_data[15:8];
      `ECIT_IDX_C1_RISE: rd_byte = slot_data[23:16];
      `ECIT_IDX_C1_FALL: rd_byte = slot_data[31:24];
      `ECIT_IDX_INT_LOW: rd_byte = icount_r[7:0];
      `ECIT_IDX_INT_HIGH: rd_byte = {4'h0, ihold_r};
      `ECIT_IDX_REL_LOW: rd_byte = reload_low_r;
      `ECIT_IDX_REL_HIGH: rd_byte = {4'h0, reload_high_r};
      `ECIT_IDX_CONFIG: rd_byte = config_r;
      `ECIT_IDX_CAP_MASK: rd_byte = {4'h0, cap_mask_r};
      `ECIT_IDX_CAP_STAT: rd_byte = {4'h0, cap_stat_r};
      `ECIT_IDX_INT_STAT: rd_byte = {7'h00, int_stat_r};
      `ECIT_IDX_INT_MASK: rd_byte = {7'h00, int_mask_r};
      default: rd_byte = 8'h00;
    endcase
  end

  // ****************************************
  // axi4-lite handshakes
  // ****************************************
  always @(posedge CLK) begin
    if (RESET) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `ECIT_RESP_OKAY;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `ECIT_RESP_OKAY;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_idx_r <= 6'h00;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_got_r && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY <= !w_got_r && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_r <= 1'b1;
        aw_idx_r <= S_AXI_AWADDR[7:2];
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_r <= 1'b1;
        wbyte_r <= S_AXI_WDATA[7:0];
        wlane_r <= S_AXI_WSTRB[0];
      end
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= mapped(aw_idx_r) ? `ECIT_RESP_OKAY : `ECIT_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (rd_fire) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= {24'h000000, rd_byte};
        S_AXI_RRESP <= mapped(ar_idx) ? `ECIT_RESP_OKAY : `ECIT_RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ****************************************
  // timers and registers
  // ****************************************
  wire wr_frt_low = hit(wr_ok, aw_idx_r, `ECIT_IDX_FRT_LOW);
  wire wr_frt_high = hit(wr_ok, aw_idx_r, `ECIT_IDX_FRT_HIGH);
  wire wr_int_low = hit(wr_ok, aw_idx_r, `ECIT_IDX_INT_LOW);
  wire wr_int_high = hit(wr_ok, aw_idx_r, `ECIT_IDX_INT_HIGH);
  wire wr_rel_low = hit(wr_ok, aw_idx_r, `ECIT_IDX_REL_LOW);
  wire wr_rel_high = hit(wr_ok, aw_idx_r, `ECIT_IDX_REL_HIGH);
  wire wr_config = hit(wr_ok, aw_idx_r, `ECIT_IDX_CONFIG);
  wire wr_cap_mask = hit(wr_ok, aw_idx_r, `ECIT_IDX_CAP_MASK);
  wire wr_cap_stat = hit(wr_ok, aw_idx_r, `ECIT_IDX_CAP_STAT);
  wire wr_int_stat = hit(wr_ok, aw_idx_r, `ECIT_IDX_INT_STAT);
  wire wr_int_mask = hit(wr_ok, aw_idx_r, `ECIT_IDX_INT_MASK);
  // a low read freezes the upper part so the pair reads coherently
  wire rd_frt_low = hit(rd_ok, ar_idx, `ECIT_IDX_FRT_LOW);
  wire rd_int_low = hit(rd_ok, ar_idx, `ECIT_IDX_INT_LOW);
  wire icount_tc = (icount_r == 12'h000);
  wire [15:0] frt_nxt = frt_r + 16'h0001;
  wire [11:0] icount_nxt = icount_r - 12'h001;
  always @(posedge CLK) begin
    if (RESET) begin
      frt_r <= 16'h0000;
      frt_hold_r <= `ECIT_RESET_BYTE;
      frt_wlow_r <= `ECIT_RESET_BYTE;
      icount_r <= 12'h000;
      ihold_r <= 4'h0;
      reload_low_r <= `ECIT_RESET_BYTE;
      reload_high_r <= 4'h0;
      reload_r <= 12'h000;
    end else begin
      // low write staged; timer takes the pair when the high byte lands
      if (wr_frt_low) begin
        frt_wlow_r <= wbyte_r;
      end
      if (wr_frt_high) begin
        frt_r <= {wbyte_r, frt_wlow_r};
      end else begin
        frt_r <= frt_nxt;
      end
      if (rd_frt_low) begin
        frt_hold_r <= frt_r[15:8];
      end
      if (rd_int_low) begin
        ihold_r <= icount_r[11:8];
      end
      // reload takes effect only on the nibble write; low first
      if (wr_rel_low) begin
        reload_low_r <= wbyte_r;
      end
      if (wr_rel_high) begin
        reload_high_r <= wbyte_r[3:0];
        reload_r <= {wbyte_r[3:0], reload_low_r};
      end
      if (wr_int_low) begin
        icount_r <= {icount_r[11:8], wbyte_r};
      end else if (wr_int_high) begin
        icount_r <= {wbyte_r[3:0], icount_r[7:0]};
      end else if (icount_tc) begin
        icount_r <= reload_r;
      end else begin
        icount_r <= icount_nxt;
      end
    end
  end

  // ****************************************
  // software registers and interrupt
  // ****************************************
  always @(posedge CLK) begin
    if (RESET) begin
      config_r <= `ECIT_RESET_BYTE;
      cap_mask_r <= 4'h0;
      cap_stat_r <= 4'h0;
      int_stat_r <= 1'b0;
      int_mask_r <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      if (wr_config) begin
        config_r <= wbyte_r & `ECIT_CFG_WMASK;
      end
      if (wr_cap_mask) begin
        cap_mask_r <= wbyte_r[3:0];
      end
      if (wr_int_mask) begin
        int_mask_r <= wbyte_r[0];
      end
      // set beats write-one-to-clear
      cap_stat_r <= (cap_stat_r & ~(wr_cap_stat ? wbyte_r[3:0] : 4'h0)) | slot_ev;
      int_stat_r <= (int_stat_r & ~(wr_int_stat & wbyte_r[0])) | icount_tc;
      // registered so the pin never glitches on a decode
      IRQ <= |(cap_stat_r & cap_mask_r) | (int_stat_r & int_mask_r);
    end
  end
endmodule // ecit_top

// ===== testbench/ecit_pin_src.sv
// edge source model driving one capture pin
module ecit_pin_src (
  input wire logic clk,
  input wire logic go,
  input wire logic [9:0] width,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] cnt_r;
  initial begin
    pin = 1'b0;
    cnt_r = 10'h000;
  end
  // a zero width leaves the pin quiet
  always @(posedge clk) begin
    if (go && width != 10'h000) begin
      pin <= 1'b1;
      cnt_r <= width;
    end else if (cnt_r == 10'h001) begin
      pin <= 1'b0;
      cnt_r <= 10'h000;
    end else if (cnt_r != 10'h000) begin
      cnt_r <= cnt_r - 10'h001;
    end
  end
endmodule // ecit_pin_src

// ===== testbench/ecit_top_asserts.sv
// bus handshake and read data assertions for the capture and interval timer
module ecit_checker (
  input wire CLK,
  input wire RESET,
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [1:0] S_AXI_BRESP,
  input wire S_AXI_ARVALID,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire [31:0] S_AXI_RDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  chk_aw_pulse: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
    else $error("awready longer than one cycle");
  chk_b_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY |-> ##[1:3] S_AXI_BVALID)
    else $error("write response late");
  chk_b_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  chk_b_drops: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response repeated");
  chk_r_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data late");
  chk_r_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  chk_r_drops: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read data repeated");
  chk_r_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("read data upper bits set");
  chk_r_order: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("second read taken early");
  chk_ihigh_resv: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    && S_AXI_ARADDR[7:2] == 6'h27 |=> S_AXI_RDATA[7:4] == 4'h0)
    else $error("interval high reserved bits set");
endmodule // ecit_checker
bind ecit_top ecit_checker chk_u (.CLK(CLK), .RESET(RESET), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_RDATA(S_AXI_RDATA));

// ===== testbench/tb.sv
// self-checking testbench for the capture and interval timer
`include "ecit_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset = 1'b1, go = 1'b0, pin0, pin1, irq;
  logic [9:0] w0 = 10'h000, w1 = 10'h000;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, a, b, c, d;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [3:0] wstrb = 4'h1;
  int mismatches = 0, check_count = 0, cycles = 0, ar_at = 0;
  always #10 clk = ~clk;
  ecit_top dut_u (.CLK(clk), .RESET(reset), .CAPTURE_INPUT_ZERO(pin0),
    .CAPTURE_INPUT_ONE(pin1), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .IRQ(irq));
  ecit_pin_src src0_u (.clk(clk), .go(go), .width(w0), .pin(pin0));
  ecit_pin_src src1_u (.clk(clk), .go(go), .width(w1), .pin(pin1));
  // ************
  // bus and compare tasks
  // ************
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= {i[5:0], 2'b00};
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (awready === 1'b1 && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !wd) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // late bready makes the response wait
    repeat (2) @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] v);
    araddr <= {i[5:0], 2'b00};
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    ar_at = cycles;
    arvalid <= 1'b0;
    repeat (2) @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    v = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic pulse(input logic [9:0] a0, input logic [9:0] a1);
    w0 <= a0;
    w1 <= a1;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat ((a0 > a1 ? a0 : a1) + 8) @(posedge clk);
  endtask
  task automatic rd4();
    rd(`ECIT_IDX_C0_RISE, a);
    rd(`ECIT_IDX_C0_FALL, b);
    rd(`ECIT_IDX_C1_RISE, c);
    rd(`ECIT_IDX_C1_FALL, d);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ************
  // scenarios
  // ************
  task automatic t_reset();
    for (int i = 8'h22; i <= 8'h28; i++) begin
      rd(8'(i), a);
      cmp(a, 8'h00);
      cmp(r, `ECIT_RESP_OKAY);
    end
    $display("done: reset values");
  endtask
  // gaps of k steps of 2**n clocks give a slice difference of exactly k
  task automatic t_select();
    for (int n = 0; n < 8; n++) begin
      wr(`ECIT_IDX_CONFIG, {1'b0, 3'(n), 4'h0});
      pulse(10'(4 << n), 10'(6 << n));
      rd4();
      cmp(8'(b - a), 8'h04);
      cmp(8'(d - c), 8'h06);
    end
    $display("done: bit select");
  endtask
  task automatic t_wide();
    wr(`ECIT_IDX_CONFIG, 8'h08);
    pulse(10'h12C, 10'h064);
    rd4();
    cmp({d, b} - {c, a}, 16'h012C);
    $display("done: wide mode");
  endtask
  task automatic t_hold();
    rd4();
    wr(`ECIT_IDX_CONFIG, 8'h80);
    pulse(10'h014, 10'h000);
    pulse(10'h032, 10'h000);
    rd4();
    cmp(8'(b - a), 8'h14);
    wr(`ECIT_IDX_CONFIG, 8'h00);
    pulse(10'h014, 10'h000);
    pulse(10'h032, 10'h000);
    rd4();
    cmp(8'(b - a), 8'h32);
    $display("done: first edge hold");
  endtask
  task automatic t_irq();
    rd(`ECIT_IDX_CAP_STAT, a);
    cmp(a, 8'h0F);
    cmp(irq, 1'b0);
    wr(`ECIT_IDX_CAP_MASK, 8'h01);
    cmp(irq, 1'b1);
    wr(`ECIT_IDX_CAP_STAT, 8'h01);
    rd(`ECIT_IDX_CAP_STAT, a);
    cmp(a, 8'h0E);
    cmp(irq, 1'b0);
    wr(`ECIT_IDX_CAP_MASK, 8'h00);
    $display("done: capture interrupt");
  endtask
  task automatic t_interval();
    int n0;
    logic [11:0] ev;
    wr(`ECIT_IDX_REL_LOW, 8'h23);
    wr(`ECIT_IDX_REL_HIGH, 8'h01);
    wr(`ECIT_IDX_INT_STAT, 8'h01);
    repeat (300) @(posedge clk);
    rd(`ECIT_IDX_INT_LOW, a);
    n0 = ar_at;
    rd(`ECIT_IDX_INT_HIGH, b);
    cmp(b[7:4], 4'h0);
    cmp({b[3:0], a} <= 12'h123, 1'b1);
    repeat (40) @(posedge clk);
    rd(`ECIT_IDX_INT_HIGH, c);
    cmp(c, b);
    rd(`ECIT_IDX_INT_LOW, d);
    cmp(d !== a, 1'b1);
    // reload 0x123 counted down to zero repeats every 0x124 clocks
    ev = 12'((int'({b[3:0], a}) + 2 * 32'h124 - (ar_at - n0)) % 32'h124);
    rd(`ECIT_IDX_INT_HIGH, c);
    cmp({c[3:0], d}, ev);
    rd(`ECIT_IDX_INT_STAT, a);
    cmp(a, 8'h01);
    wr(`ECIT_IDX_INT_MASK, 8'h01);
    cmp(irq, 1'b1);
    wr(`ECIT_IDX_INT_MASK, 8'h00);
    cmp(irq, 1'b0);
    $display("done: interval timer");
  endtask
  task automatic t_unmapped();
    rd(8'h3F, a);
    cmp(r, `ECIT_RESP_SLVERR);
    cmp(a, 8'h00);
    wr(8'h3F, 8'h55);
    cmp(r, `ECIT_RESP_SLVERR);
    // a write without lane zero is answered but leaves the register alone
    wstrb <= 4'h0;
    wr(`ECIT_IDX_CAP_MASK, 8'h0F);
    cmp(r, `ECIT_RESP_OKAY);
    wstrb <= 4'h1;
    rd(`ECIT_IDX_CAP_MASK, a);
    cmp(a, 8'h00);
    $display("done: unmapped address");
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_select();
    t_wide();
    t_hold();
    t_irq();
    t_interval();
    t_unmapped();
    print_verdict();
  end
endmodule // tb
